/* design/rr_pkg.sv */
// Shared constants, types and states of the repeater forwarding block.
package rr_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int RELOAD_TIME_NS = 1000;
    localparam int RELOAD_CYCLES = (RELOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] RELOAD_LAST = 6'(RELOAD_CYCLES - 1);

    // ------------------------------------------------------------------
    // Sizes and field positions
    // ------------------------------------------------------------------
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 32;
    localparam int TAG_HIST = 4;
    localparam int REG3_REPEAT_BIT = 5;
    localparam logic [15:0] BCAST_ADDR = 16'hffff;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_WOR,
        MODE_CONFIG,
        MODE_SLEEP
    } rr_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX_PASS,
        ST_RX_DROP,
        ST_HOST_PASS,
        ST_DRAIN
    } rr_state_t;

    typedef struct packed {
        logic [7:0] address_high_byte;
        logic [7:0] address_low_byte;
        logic [7:0] network_identifier;
        logic [7:0] reg0;
        logic [7:0] reg1;
        logic [7:0] channel;
        logic [7:0] reg3;
        logic [15:0] key;
    } rr_cfg_t;

    typedef struct packed {
        logic [7:0] network_identifier;
        logic [7:0] tag;
        logic [15:0] addr;
    } rr_hdr_t;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } rr_word_t;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam rr_cfg_t FACTORY_CFG = '{
        address_high_byte: 8'h00,
        address_low_byte: 8'h00,
        network_identifier: 8'h00,
        reg0: 8'h62,
        reg1: 8'h00,
        channel: 8'h17,
        reg3: 8'h00,
        key: 16'h0000
    };

endpackage : rr_pkg

/* design/rr_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module rr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Status
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic full;
    logic push;
    logic pop;

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_comb begin
        next_wr_ptr = wr_ptr + (AW + 1)'(push);
        next_rd_ptr = rd_ptr + (AW + 1)'(pop);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // The array holds no reset so that it maps onto plain storage.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

endmodule : rr_fifo

/* design/rr_param_store.sv */
// Saved and active parameter sets with the reload sequence.
`timescale 1ns/1ps
module rr_param_store (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Mode and configuration
    input wire rr_pkg::rr_mode_t mode,
    input wire logic cfg_wr,
    input wire rr_pkg::rr_cfg_t cfg_in,
    input wire logic factory_reset,
    // Results
    output rr_pkg::rr_cfg_t active,
    output logic busy
);
    rr_pkg::rr_cfg_t saved;
    rr_pkg::rr_cfg_t next_saved;
    rr_pkg::rr_cfg_t next_active;
    logic next_busy;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    rr_pkg::rr_mode_t prev_mode;

    always_comb begin
        next_saved = saved;
        next_active = active;
        next_busy = busy;
        next_cnt = cnt;
        if (factory_reset) begin
            next_saved = rr_pkg::FACTORY_CFG;
        end else if (cfg_wr && mode == rr_pkg::MODE_CONFIG) begin
            next_saved = cfg_in;
            next_active = cfg_in;
        end
        if (prev_mode == rr_pkg::MODE_SLEEP && mode != rr_pkg::MODE_SLEEP) begin
            next_busy = 1'b1;
            next_cnt = '0;
        end else if (busy) begin
            if (cnt == rr_pkg::RELOAD_LAST) begin
                next_busy = 1'b0;
                next_active = saved;
            end else begin
                next_cnt = cnt + 6'h01;
            end
        end
    end

    // Reset itself starts a reload, so busy comes up high.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            saved <= rr_pkg::FACTORY_CFG;
            active <= rr_pkg::FACTORY_CFG;
            busy <= 1'b1;
            cnt <= '0;
            prev_mode <= rr_pkg::MODE_NORMAL;
        end else begin
            saved <= next_saved;
            active <= next_active;
            busy <= next_busy;
            cnt <= next_cnt;
            prev_mode <= mode;
        end
    end

endmodule : rr_param_store

/* design/rr_repeater.sv */
// Frame forwarding core of a radio module acting as a packet repeater.
`timescale 1ns/1ps
// What this block does
// - Repeat only when configured and mode normal.
// - Address bytes become a network pair.
// - Frame from one network goes to other.
// - Own network identifier ignored while repeating.
// - No host data, no low power when repeating.
// - Reload parameters, status low until done.
// - Forward high-byte network to low, and back.
// - A frame is relayed once; a tag among the last four relayed is dropped.
// - Deliver only frames whose address matches.
// - Factory reset restores documented default parameters; the saved set at once, the active set only at the next reload.
// - Third option register bit five enables repeating.
module rr_repeater (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Mode pins and configuration
    input wire logic [1:0] mode_pin,
    input wire logic cfg_wr,
    input wire rr_pkg::rr_cfg_t cfg_in,
    input wire logic factory_reset,
    // Radio receive
    input wire logic rx_valid,
    output logic rx_ready,
    input wire rr_pkg::rr_word_t rx_word,
    input wire rr_pkg::rr_hdr_t rx_hdr,
    // Radio transmit
    output logic tx_valid,
    input wire logic tx_ready,
    output rr_pkg::rr_word_t tx_word,
    output rr_pkg::rr_hdr_t tx_hdr,
    // Host data
    input wire logic host_tx_valid,
    output logic host_tx_ready,
    input wire rr_pkg::rr_word_t host_tx_word,
    output logic host_rx_valid,
    input wire logic host_rx_ready,
    output rr_pkg::rr_word_t host_rx_word,
    // Status
    output logic aux,
    output logic repeating,
    output logic low_power_ok,
    output rr_pkg::rr_cfg_t active_cfg
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic tag_seen(input logic [rr_pkg::TAG_HIST*8-1:0] h,
                                      input logic [rr_pkg::TAG_HIST-1:0] v,
                                      input logic [7:0] t);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < rr_pkg::TAG_HIST; i++) begin
            if (v[i] && h[i*8 +: 8] == t) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : tag_seen

    function automatic logic addr_match(input logic [15:0] a, input logic [15:0] own);
        return (a == own) || (a == rr_pkg::BCAST_ADDR);
    endfunction : addr_match

    // ------------------------------------------------------------------
    // Mode pins and parameters
    // ------------------------------------------------------------------
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    rr_pkg::rr_mode_t mode;
    logic busy;
    logic repeat_cfg;
    logic rep;
    logic [15:0] own_addr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_s1 <= 2'h0;
            mode_s2 <= 2'h0;
        end else begin
            mode_s1 <= mode_pin;
            mode_s2 <= mode_s1;
        end
    end

    assign mode = rr_pkg::rr_mode_t'(mode_s2);

    rr_param_store u_store (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mode(mode),
        .cfg_wr(cfg_wr),
        .cfg_in(cfg_in),
        .factory_reset(factory_reset),
        .active(active_cfg),
        .busy(busy)
    );

    assign repeat_cfg = active_cfg.reg3[rr_pkg::REG3_REPEAT_BIT];
    assign rep = repeat_cfg && mode == rr_pkg::MODE_NORMAL && !busy;
    assign repeating = rep;
    assign own_addr = {active_cfg.address_high_byte, active_cfg.address_low_byte};
    // Wake-up listening and sleep stay barred while repeating is set.
    assign low_power_ok = !repeat_cfg && (mode == rr_pkg::MODE_WOR || mode == rr_pkg::MODE_SLEEP);

    // ------------------------------------------------------------------
    // Frame router
    // ------------------------------------------------------------------
    rr_pkg::rr_state_t state;
    rr_pkg::rr_state_t next_state;
    logic dest_radio;
    logic next_dest_radio;
    rr_pkg::rr_hdr_t next_tx_hdr;
    logic [rr_pkg::TAG_HIST*8-1:0] hist;
    logic [rr_pkg::TAG_HIST*8-1:0] next_hist;
    logic [rr_pkg::TAG_HIST-1:0] hist_v;
    logic [rr_pkg::TAG_HIST-1:0] next_hist_v;
    logic [7:0] host_tag;
    logic [7:0] next_host_tag;
    logic rx_start;
    logic host_start;
    logic dup;
    logic deliverable;
    logic fifo_in_valid;
    logic fifo_in_ready;
    rr_pkg::rr_word_t fifo_in_word;
    logic fifo_out_valid;
    logic fifo_out_ready;
    rr_pkg::rr_word_t fifo_out_word;
    logic fifo_empty;

    assign rx_start = state == rr_pkg::ST_IDLE && rx_valid && !busy;
    assign host_start = state == rr_pkg::ST_IDLE && !rx_valid && host_tx_valid && !busy && !rep
                        && mode == rr_pkg::MODE_NORMAL;
    assign dup = tag_seen(hist, hist_v, rx_hdr.tag);
    assign deliverable = (mode == rr_pkg::MODE_NORMAL || mode == rr_pkg::MODE_WOR)
                         && rx_hdr.network_identifier == active_cfg.network_identifier
                         && addr_match(rx_hdr.addr, own_addr);

    always_comb begin
        next_state = state;
        next_dest_radio = dest_radio;
        next_tx_hdr = tx_hdr;
        next_hist = hist;
        next_hist_v = hist_v;
        next_host_tag = host_tag;
        rx_ready = 1'b0;
        host_tx_ready = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_in_word = rx_word;
        case (state)
            rr_pkg::ST_IDLE: begin
                if (rx_start) begin
                    next_state = rr_pkg::ST_RX_DROP;
                    if (rep) begin
                        // The address bytes name the network pair; the own
                        // identifier plays no part. A tag among the last four relayed is dropped.
                        if (!dup && rx_hdr.network_identifier == active_cfg.address_high_byte) begin
                            next_state = rr_pkg::ST_RX_PASS;
                            next_dest_radio = 1'b1;
                            next_tx_hdr = '{network_identifier: active_cfg.address_low_byte,
                                            tag: rx_hdr.tag, addr: rx_hdr.addr};
                        end else if (!dup && rx_hdr.network_identifier == active_cfg.address_low_byte) begin
                            next_state = rr_pkg::ST_RX_PASS;
                            next_dest_radio = 1'b1;
                            next_tx_hdr = '{network_identifier: active_cfg.address_high_byte,
                                            tag: rx_hdr.tag, addr: rx_hdr.addr};
                        end
                        if (next_state == rr_pkg::ST_RX_PASS) begin
                            next_hist = {hist[(rr_pkg::TAG_HIST-1)*8-1:0], rx_hdr.tag};
                            next_hist_v = {hist_v[rr_pkg::TAG_HIST-2:0], 1'b1};
                        end
                    end else if (deliverable) begin
                        next_state = rr_pkg::ST_RX_PASS;
                        next_dest_radio = 1'b0;
                    end
                end else if (host_start) begin
                    next_state = rr_pkg::ST_HOST_PASS;
                    next_dest_radio = 1'b1;
                    next_tx_hdr = '{network_identifier: active_cfg.network_identifier,
                                    tag: host_tag, addr: own_addr};
                    next_host_tag = host_tag + 8'h01;
                end
            end
            rr_pkg::ST_RX_PASS: begin
                rx_ready = fifo_in_ready;
                fifo_in_valid = rx_valid;
                if (rx_valid && fifo_in_ready && rx_word.last) begin
                    next_state = rr_pkg::ST_DRAIN;
                end
            end
            rr_pkg::ST_RX_DROP: begin
                rx_ready = 1'b1;
                if (rx_valid && rx_word.last) begin
                    next_state = rr_pkg::ST_IDLE;
                end
            end
            rr_pkg::ST_HOST_PASS: begin
                host_tx_ready = fifo_in_ready;
                fifo_in_valid = host_tx_valid;
                fifo_in_word = host_tx_word;
                if (host_tx_valid && fifo_in_ready && host_tx_word.last) begin
                    next_state = rr_pkg::ST_DRAIN;
                end
            end
            rr_pkg::ST_DRAIN: begin
                if (fifo_empty) begin
                    next_state = rr_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = rr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rr_pkg::ST_IDLE;
            dest_radio <= 1'b0;
            tx_hdr <= '0;
            hist <= '0;
            hist_v <= '0;
            host_tag <= 8'h00;
        end else begin
            state <= next_state;
            dest_radio <= next_dest_radio;
            tx_hdr <= next_tx_hdr;
            hist <= next_hist;
            hist_v <= next_hist_v;
            host_tag <= next_host_tag;
        end
    end

    // ------------------------------------------------------------------
    // Frame buffer and sinks
    // ------------------------------------------------------------------
    // One frame at a time: the destination only changes once the buffer is
    // empty, which costs a gap between frames but keeps routing trivial.
    rr_fifo #(
        .WIDTH(rr_pkg::FIFO_WIDTH),
        .DEPTH(rr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_word),
        .empty(fifo_empty)
    );

    assign fifo_out_ready = dest_radio ? tx_ready : host_rx_ready;
    assign tx_valid = fifo_out_valid && dest_radio;
    assign tx_word = fifo_out_word;
    assign host_rx_valid = fifo_out_valid && !dest_radio;
    assign host_rx_word = fifo_out_word;
    assign aux = !busy && fifo_empty && state == rr_pkg::ST_IDLE;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_aux_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy |-> !aux) else $error("status high during parameter reload");

    a_repeat_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        rep |-> (mode == rr_pkg::MODE_NORMAL && active_cfg.reg3[5])) else $error("repeating without setup");

    a_no_low_power: assert property (@(posedge core_clk) disable iff (!rst_n)
        active_cfg.reg3[5] |-> !low_power_ok) else $error("low power allowed while repeating");

    a_no_host_take: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == rr_pkg::ST_IDLE && rep) |=> state != rr_pkg::ST_HOST_PASS) else $error("host frame taken");

    a_fwd_high_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_start && rep && !dup && rx_hdr.network_identifier == active_cfg.address_high_byte)
        |=> (state == rr_pkg::ST_RX_PASS && dest_radio
             && tx_hdr.network_identifier == $past(active_cfg.address_low_byte)))
        else $error("high network not forwarded to low");

    a_fwd_low_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_start && rep && !dup && rx_hdr.network_identifier == active_cfg.address_low_byte
         && active_cfg.address_low_byte != active_cfg.address_high_byte)
        |=> (state == rr_pkg::ST_RX_PASS
             && tx_hdr.network_identifier == $past(active_cfg.address_high_byte)))
        else $error("low network not forwarded to high");

    a_foreign_net: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_start && rep && rx_hdr.network_identifier != active_cfg.address_high_byte
         && rx_hdr.network_identifier != active_cfg.address_low_byte)
        |=> state == rr_pkg::ST_RX_DROP) else $error("frame from unpaired network kept");

    a_relay_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_start && rep && dup) |=> state == rr_pkg::ST_RX_DROP) else $error("frame relayed twice");

    a_addr_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rx_start && !rep && !addr_match(rx_hdr.addr, own_addr))
        |=> (state == rr_pkg::ST_RX_DROP ##1 !host_rx_valid)) else $error("mismatched frame delivered");

endmodule : rr_repeater

/* dv/rr_peer.sv */
// Radio peer model that offers frames to the block and takes its transmitted words.
`timescale 1ns/1ps
module rr_peer (
    // Clock and stall control
    input wire logic core_clk,
    input wire logic stall,
    // Receive side of the block
    output logic rx_valid,
    input wire logic rx_ready,
    output rr_pkg::rr_word_t rx_word,
    output rr_pkg::rr_hdr_t rx_hdr,
    // Transmit side of the block
    input wire logic tx_valid,
    output logic tx_ready,
    input wire rr_pkg::rr_word_t tx_word,
    input wire rr_pkg::rr_hdr_t tx_hdr
);
    logic [2:0] cnt = 3'h0;
    logic [40:0] got_q[$];
    initial begin
        rx_valid = 1'b0;
        rx_word = 9'h0aa;
        rx_hdr = 32'h0;
    end
    // Two idle cycles in eight keep words waiting in the buffer.
    assign tx_ready = !stall && cnt > 3'h1;
    always @(posedge core_clk) begin
        cnt <= cnt + 3'h1;
        if (tx_valid && tx_ready)
            got_q.push_back({tx_hdr, tx_word});
    end
    // Header and byte stand until rx_ready is seen at a rising edge; released lines flip.
    task automatic send(input rr_pkg::rr_hdr_t hdr, input logic [7:0] b[64], input int n);
        int i;
        i = 0;
        while (i < n) begin
            rx_hdr <= hdr;
            rx_valid <= 1'b1;
            rx_word <= {i == n - 1, b[i]};
            @(posedge core_clk);
            if (rx_ready)
                i++;
        end
        rx_valid <= 1'b0;
        rx_word <= ~rx_word;
        rx_hdr <= ~hdr;
    endtask : send
endmodule : rr_peer

/* dv/tb.sv */
// Self-checking bench of the repeater forwarding block.
`timescale 1ns/1ps
module tb;
    localparam int MAX_CYC = 20000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] mode_pin = 2'h0;
    logic cfg_wr = 1'b0;
    logic factory_reset = 1'b0;
    logic stall = 1'b0;
    logic host_tx_valid = 1'b0;
    logic host_rx_ready = 1'b0;
    logic leak = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, host_tx_ready, host_rx_valid, aux, repeating, low_power_ok;
    rr_pkg::rr_cfg_t cfg_in = '0;
    rr_pkg::rr_cfg_t active_cfg;
    rr_pkg::rr_word_t rx_word, tx_word, host_rx_word;
    rr_pkg::rr_word_t host_tx_word = 9'h1a5;
    rr_pkg::rr_hdr_t rx_hdr, tx_hdr;
    logic [31:0] lfsr = 32'h306b;
    logic [8:0] host_q[$];
    logic [40:0] exp_q[$];
    logic [7:0] bytes[64];
    int err_total = 0;
    int compares = 0;
    int cyc = 0;

    rr_repeater dut_u (.core_clk(core_clk), .rst_n(rst_n), .mode_pin(mode_pin), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
        .factory_reset(factory_reset), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .rx_hdr(rx_hdr),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word), .tx_hdr(tx_hdr), .host_tx_valid(host_tx_valid),
        .host_tx_ready(host_tx_ready), .host_tx_word(host_tx_word), .host_rx_valid(host_rx_valid),
        .host_rx_ready(host_rx_ready), .host_rx_word(host_rx_word), .aux(aux), .repeating(repeating),
        .low_power_ok(low_power_ok), .active_cfg(active_cfg));
    rr_peer peer_u (.core_clk(core_clk), .stall(stall), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
        .rx_hdr(rx_hdr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word), .tx_hdr(tx_hdr));

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic chk_val(input logic [40:0] got, input logic [40:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({40'h0, got}, {40'h0, exp});
    endtask : chk_bit
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic wait_aux(output int n);
        n = 0;
        while (aux !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk_bit(aux, 1'b1);
    endtask : wait_aux
    task automatic configure(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] net, input logic [7:0] r3);
        mode_pin <= 2'h2;
        tick(4);
        cfg_in <= '{hi, lo, net, 8'h62, 8'h00, 8'h17, r3, 16'h0000};
        cfg_wr <= 1'b1;
        tick(1);
        cfg_wr <= 1'b0;
        mode_pin <= 2'h0;
        tick(4);
    endtask : configure
    // Dest 1 expects the frame on the radio under out_net, dest 2 at the host, dest 0 nowhere.
    task automatic run_frame(input logic [7:0] net, input logic [7:0] tag, input logic [15:0] addr, input int n,
                             input logic [1:0] dest, input logic [7:0] out_net, input int hold);
        logic [31:0] r;
        int w;
        r = lfsr;
        for (int i = 0; i < n; i++) begin
            r = nxt(r);
            bytes[i] = r[7:0];
            if (dest == 2'h1)
                exp_q.push_back({out_net, tag, addr, i == n - 1, bytes[i]});
            if (dest == 2'h2)
                exp_q.push_back({32'h0, i == n - 1, bytes[i]});
        end
        fork
            peer_u.send({net, tag, addr}, bytes, n);
            if (hold > 0) begin
                stall <= 1'b1;
                tick(hold - 5);
                chk_bit(rx_ready, 1'b0);
                tick(5);
                stall <= 1'b0;
            end
        join
        tick(1);
        wait_aux(w);
        tick(2);
        chk_val(41'(peer_u.got_q.size() + host_q.size()), 41'(exp_q.size()));
        foreach (exp_q[i])
            chk_val(dest == 2'h1 ? peer_u.got_q[i] : {32'h0, host_q[i]}, exp_q[i]);
        exp_q.delete();
        host_q.delete();
        peer_u.got_q.delete();
    endtask : run_frame

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        lfsr <= nxt(lfsr);
        host_rx_ready <= lfsr[3];
        if (host_rx_valid && host_rx_ready)
            host_q.push_back(host_rx_word);
        if (repeating && host_tx_ready)
            leak <= 1'b1;
        if (cyc == MAX_CYC) begin
            err_total++;
            give_verdict();
        end
    end

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        int w;
        tick(4);
        rst_n <= 1'b1;
        tick(3);
        chk_bit(aux, 1'b0);
        chk_val(41'({active_cfg.address_high_byte, active_cfg.address_low_byte, active_cfg.channel}), 41'h17);
        wait_aux(w);
        chk_bit(w > 30, 1'b1);
        configure(8'h08, 8'h33, 8'h77, 8'h20);
        chk_bit(repeating, 1'b1);
        mode_pin <= 2'h1;
        tick(4);
        chk_bit(low_power_ok, 1'b0);
        chk_bit(repeating, 1'b0);
        mode_pin <= 2'h0;
        tick(4);
        host_tx_valid <= 1'b1;
        run_frame(8'h08, 8'h01, 16'h1111, 5, 2'h1, 8'h33, 0);
        run_frame(8'h33, 8'h02, 16'h2222, 40, 2'h1, 8'h08, 50);
        run_frame(8'h77, 8'h03, 16'h3333, 4, 2'h0, 8'h00, 0);
        run_frame(8'h08, 8'h01, 16'h1111, 4, 2'h0, 8'h00, 0);
        run_frame(8'h08, 8'h04, 16'h0833, 3, 2'h1, 8'h33, 0);
        host_tx_valid <= 1'b0;
        chk_bit(leak, 1'b0);
        configure(8'h12, 8'h34, 8'h55, 8'h00);
        chk_bit(repeating, 1'b0);
        run_frame(8'h55, 8'h05, 16'h1234, 6, 2'h2, 8'h00, 0);
        run_frame(8'h55, 8'h06, 16'h4321, 6, 2'h0, 8'h00, 0);
        run_frame(8'h55, 8'h07, 16'hffff, 2, 2'h2, 8'h00, 0);
        host_tx_word <= {1'b1, lfsr[7:0]};
        host_tx_valid <= 1'b1;
        w = 0;
        do begin
            tick(1);
            w++;
        end while (host_tx_ready !== 1'b1 && w < 50);
        host_tx_valid <= 1'b0;
        tick(1);
        wait_aux(w);
        chk_val(41'({peer_u.got_q[0][40:33], peer_u.got_q[0][24:9]}), 41'h551234);
        chk_val(41'(peer_u.got_q[0][8:0]), 41'(host_tx_word));
        peer_u.got_q.delete();
        mode_pin <= 2'h1;
        tick(4);
        chk_bit(low_power_ok, 1'b1);
        run_frame(8'h55, 8'h08, 16'h1234, 2, 2'h2, 8'h00, 0);
        factory_reset <= 1'b1;
        tick(1);
        factory_reset <= 1'b0;
        mode_pin <= 2'h3;
        tick(4);
        mode_pin <= 2'h0;
        tick(4);
        chk_bit(aux, 1'b0);
        wait_aux(w);
        chk_val(41'({active_cfg.address_high_byte, active_cfg.address_low_byte, active_cfg.channel}), 41'h17);
        give_verdict();
    end
endmodule : tb
